// File: bench/core_sram_system_interface_bench.sv
// self-checking bench for the core sram interface
`timescale 1ns/1ns
`default_nettype none
module core_sram_system_interface_bench;
   import csi_pkg::*;
   logic clk_i = 1'h0, reset_i = 1'h1, core_i_valid_i = 1'h0;
   logic core_i_call_i = 1'h0, core_d_valid_i = 1'h0, core_d_write_i = 1'h0;
   logic core_d_lock_i = 1'h0, core_d_sync_i = 1'h0, irq_detect_i = 1'h0;
   logic fetch_abort_i = 1'h0, wait_exec_i = 1'h0, dside_redirect_i = 1'h0;
   logic debug_reset_mask_i = 1'h0, warm_reset_in_i = 1'h0;
   logic cold_reset_in_i = 1'h0, interrupt_pin_i = 1'h0, nmi_pin_i = 1'h0;
   logic [31:0] core_i_addr_i = 32'h0, core_d_addr_i = 32'h0;
   logic [31:0] core_d_wdata_i = 32'h0, status_word_i = 32'h0;
   logic [31:0] debug_word_i = 32'h0;
   logic [3:0] core_d_be_i = 4'hf;
   logic core_i_ready_o, core_i_done_o, core_i_aborted_o, core_d_ready_o;
   logic core_d_done_o, core_d_aborted_o, ip_req_o, ip_dside_o, ip_write_o;
   logic ip_lock_o, ip_sync_o, ip_call_o, ip_abort_o, ip_stall_i;
   logic ip_abort_ack_i, dp_req_o, dp_write_o, dp_lock_o, dp_sync_o;
   logic dp_abort_o, dp_stall_i, dp_abort_ack_i, reset_exception_o;
   logic soft_reset_flag_o, reduced_power_out_o, exception_level_out_o;
   logic error_level_out_o, debug_mode_out_o, sleep_o, core_clk_en_o;
   logic [31:0] core_i_rdata_o, core_d_rdata_o, ip_addr_o, ip_wdata_o;
   logic [31:0] ip_rdata_i, dp_addr_o, dp_wdata_o, dp_rdata_i;
   logic [3:0] ip_be_o, ip_rbe_i, dp_be_o, dp_rbe_i;
   logic [3:0] ip_sn = 4'h0, dp_sn = 4'h0;
   logic [3:0] lv, ev;
   logic ip_nar = 1'h0, ip_ack = 1'h0, seen, u_ir, u_dr;
   logic [34:0] qi[$], qd[$], ei, ed;
   logic [4:0] tab [5] = '{5'h13, 5'h0a, 5'h1a, 5'h14, 5'h1e};
   integer seed = 32'h4114, n_mismatch = 0, num_checks = 0;
   time t_i, t_d;

   csi_top #(.UNIFIED(1'b0), .DEBUG_MASK_EN(1'b1)) dut (.*);
   // unified build on the same core requests, watched for grant order
   csi_top #(.UNIFIED(1'b1), .DEBUG_MASK_EN(1'b1)) dut_u (.*,
      .core_i_ready_o(u_ir), .core_d_ready_o(u_dr), .core_i_done_o(),
      .core_i_aborted_o(), .core_i_rdata_o(), .core_d_done_o(),
      .core_d_aborted_o(), .core_d_rdata_o(), .ip_req_o(), .ip_dside_o(),
      .ip_write_o(), .ip_addr_o(), .ip_wdata_o(), .ip_be_o(), .ip_lock_o(),
      .ip_sync_o(), .ip_call_o(), .ip_abort_o(), .dp_req_o(), .dp_write_o(),
      .dp_addr_o(), .dp_wdata_o(), .dp_be_o(), .dp_lock_o(), .dp_sync_o(),
      .dp_abort_o(), .reset_exception_o(), .soft_reset_flag_o(),
      .reduced_power_out_o(), .exception_level_out_o(),
      .error_level_out_o(), .debug_mode_out_o(), .sleep_o(),
      .core_clk_en_o());
   // write data and byte enables are folded into the answer word
   csi_mem_model ip_mem (.clk_i(clk_i), .req_i(ip_req_o),
      .addr_i(ip_addr_o ^ ip_wdata_o ^ {ip_be_o, 28'h0}),
      .abort_i(ip_abort_o), .stall_n_i(ip_sn),
      .flags_i({ip_dside_o, ip_call_o, ip_lock_o, ip_sync_o, ip_write_o}),
      .narrow_i(ip_nar), .ack_en_i(ip_ack), .stall_o(ip_stall_i),
      .abort_ack_o(ip_abort_ack_i), .rdata_o(ip_rdata_i), .rbe_o(ip_rbe_i));
   csi_mem_model dp_mem (.clk_i(clk_i), .req_i(dp_req_o),
      .addr_i(dp_addr_o ^ dp_wdata_o ^ {dp_be_o, 28'h0}),
      .abort_i(dp_abort_o), .stall_n_i(dp_sn),
      .flags_i({2'h0, dp_lock_o, dp_sync_o, dp_write_o}),
      .narrow_i(1'h0), .ack_en_i(1'h0), .stall_o(dp_stall_i),
      .abort_ack_o(dp_abort_ack_i), .rdata_o(dp_rdata_i), .rbe_o(dp_rbe_i));

   initial forever #5 clk_i = !clk_i;

   task automatic check(input logic ok, input string what);
      num_checks++;
      if (ok !== 1'h1) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   // note layout: present, aborted, data checked, data
   task automatic cmp(input logic [34:0] e, input logic ab,
      input logic [31:0] rd);
      check(e[34] && e[33] === ab && (!e[32] || e[31:0] === rd), "result");
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // fetch held until taken; expected data carries the call flag
   task automatic do_i(input logic [31:0] a, input logic c,
      input logic [1:0] k);
      core_i_valid_i <= 1'h1;
      core_i_addr_i <= a;
      core_i_call_i <= c;
      do @(posedge clk_i); while (core_i_ready_o !== 1'h1);
      t_i = $time;
      qi.push_back({1'h1, k, a ^ {4'hf, 24'h0, c, 3'h0}});
      core_i_valid_i <= 1'h0;
   endtask

   // data request; a redirected one comes back with the d-side flag
   task automatic do_d(input logic [31:0] a, input logic w, input logic l,
      input logic s, input logic r);
      core_d_valid_i <= 1'h1;
      core_d_addr_i <= a;
      core_d_write_i <= w;
      core_d_lock_i <= l;
      core_d_sync_i <= s;
      dside_redirect_i <= r;
      core_d_wdata_i <= $random(seed);
      core_d_be_i <= 4'($random(seed));
      do @(posedge clk_i); while (core_d_ready_o !== 1'h1);
      t_d = $time;
      qd.push_back({1'h1, 1'h0, !w, a ^ core_d_wdata_i ^
         {core_d_be_i, 23'h0, r, 1'h0, l, s, w}});
      core_d_valid_i <= 1'h0;
      dside_redirect_i <= 1'h0;
   endtask

   task automatic settle();
      repeat (60) if (qi.size() + qd.size() > 0) @(posedge clk_i);
      check(qi.size() + qd.size() == 0, "results missing");
   endtask

   // completions arrive in order, each takes the oldest note
   always @(posedge clk_i) begin
      if (core_i_done_o === 1'h1) begin
         ei = qi.size() ? qi.pop_front() : 35'h0;
         cmp(ei, core_i_aborted_o, core_i_rdata_o);
      end
      if (core_d_done_o === 1'h1) begin
         ed = qd.size() ? qd.pop_front() : 35'h0;
         cmp(ed, core_d_aborted_o, core_d_rdata_o);
      end
   end

   initial begin
      repeat (10) @(posedge clk_i);
      reset_i <= 1'h0;
      @(posedge clk_i);
      fork
         do_i(32'h100, 1'h1, 2'h1);
         do_d(32'h200, 1'h0, 1'h1, 1'h0, 1'h0);
      join
      check(t_i == t_d, "ports not parallel");
      check(u_ir === 1'h0 && u_dr === 1'h1, "unified order");
      settle();
      $display("parallel done");
      // random stalls and request kinds on both ports
      for (int n = 0; n < 12; n++) begin
         ip_sn <= 4'($random(seed)) & 4'h3;
         dp_sn <= 4'($random(seed)) & 4'h3;
         fork
            do_i($random(seed), n[0], 2'h1);
            do_d($random(seed), n[1], n[2], n[3], 1'h0);
         join
         settle();
      end
      $display("random done");
      // narrow memory builds the word one lane a cycle
      ip_nar <= 1'h1;
      ip_sn <= 4'h3;
      do_i(32'hcafe_0123, 1'h0, 2'h1);
      settle();
      ip_nar <= 1'h0;
      $display("narrow done");
      do_d(32'h0000_4440, 1'h0, 1'h0, 1'h1, 1'h1);
      settle();
      $display("redirect done");
      // long fetch hit by an abort: taken once, ignored once
      ip_sn <= 4'h8;
      for (int k = 0; k < 2; k++) begin
         ip_ack <= !k[0];
         fork
            do_i(32'h0000_0800, 1'h0, {!k[0], k[0]});
            begin
               repeat (3) @(posedge clk_i);
               irq_detect_i <= k == 0;
               fetch_abort_i <= k == 1;
               @(posedge clk_i);
               irq_detect_i <= 1'h0;
               fetch_abort_i <= 1'h0;
            end
         join
         settle();
      end
      $display("abort done");
      // status and debug words land on the pins a cycle later
      for (int n = 0; n < 8; n++) begin
         status_word_i <= $random(seed);
         debug_word_i <= $random(seed);
         repeat (2) @(posedge clk_i);
         lv = {debug_mode_out_o, exception_level_out_o, error_level_out_o,
            reduced_power_out_o};
         ev = {debug_word_i[DEBUG_MODE_POS],
            status_word_i[EXCEPTION_LEVEL_POS],
            status_word_i[ERROR_LEVEL_POS], status_word_i[REDUCED_POWER_POS]};
         check(lv[1:0] === ev[1:0], "rp");
         check(lv[3:2] === ev[3:2], "dm");
      end
      $display("mirror done");
      // table: warm, cold, debug mask, exception due, soft flag
      for (int n = 0; n < 5; n++) begin
         debug_word_i <= {1'h0, tab[n][2], 30'h0};
         debug_reset_mask_i <= tab[n][2];
         repeat (2) @(posedge clk_i);
         warm_reset_in_i <= tab[n][4];
         cold_reset_in_i <= tab[n][3];
         seen = 1'h0;
         repeat (RESET_MIN_CYC + 1) begin
            @(posedge clk_i);
            seen = seen | reset_exception_o;
         end
         check(seen === 1'h0, "exception in reset");
         warm_reset_in_i <= 1'h0;
         cold_reset_in_i <= 1'h0;
         repeat (6) begin
            @(posedge clk_i);
            seen = seen | reset_exception_o;
         end
         check(seen === tab[n][1], "exception");
         if (tab[n][1]) begin
            check(soft_reset_flag_o === tab[n][0], "flag");
         end
      end
      debug_word_i <= 32'h0;
      debug_reset_mask_i <= 1'h0;
      $display("reset done");
      // wait instruction sleeps; an interrupt, then an nmi, wakes
      for (int n = 0; n < 2; n++) begin
         wait_exec_i <= 1'h1;
         @(posedge clk_i);
         wait_exec_i <= 1'h0;
         @(posedge clk_i);
         check(sleep_o && !core_clk_en_o, "no sleep");
         interrupt_pin_i <= !n[0];
         nmi_pin_i <= n[0];
         repeat (5) @(posedge clk_i);
         check(!sleep_o && core_clk_en_o, "no wake");
         interrupt_pin_i <= 1'h0;
         nmi_pin_i <= 1'h0;
         repeat (4) @(posedge clk_i);
      end
      $display("sleep done");
      end_of_test();
   end

   // whole run is well under a thousand cycles; this means a hang
   initial begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
endmodule // core_sram_system_interface_bench
`default_nettype wire

// File: bench/csi_mem_model.sv
// memory port model with stalls, narrow lanes and abort answers
`timescale 1ns/1ns
`default_nettype none
module csi_mem_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   input wire logic [4:0] flags_i,
   input wire logic abort_i,
   input wire logic [3:0] stall_n_i,
   input wire logic narrow_i,
   input wire logic ack_en_i,
   output logic stall_o,
   output logic abort_ack_o,
   output logic [31:0] rdata_o,
   output logic [3:0] rbe_o
);
   logic [3:0] cnt_reg = 4'h0;
   logic tog_reg = 1'h0;
   logic fin;
   logic [31:0] val;
   logic [31:0] m;
   // finish once the chosen number of stall cycles has passed
   assign fin = req_i && (cnt_reg == stall_n_i);
   // the bench decides whether an abort is taken or ignored
   assign abort_ack_o = abort_i && ack_en_i;
   // idle stall line wanders so nothing may lean on it
   assign stall_o = req_i ? !fin : tog_reg;
   // narrow device: one steered lane a cycle, lowest first
   assign rbe_o = !req_i ? 4'h0 :
      narrow_i ? 4'h1 << cnt_reg[1:0] : {4{fin}};
   assign val = addr_i ^ {27'h0, flags_i};
   assign m = {{8{rbe_o[3]}}, {8{rbe_o[2]}}, {8{rbe_o[1]}}, {8{rbe_o[0]}}};
   // lanes not flagged carry the inverse, so stray capture shows
   assign rdata_o = (val & m) | (~val & ~m);
   // cycle count within the current request
   always_ff @(posedge clk_i) begin
      cnt_reg <= (req_i && !fin && !abort_ack_o) ? cnt_reg + 4'h1 : 4'h0;
      tog_reg <= !tog_reg;
   end
endmodule // csi_mem_model
`default_nettype wire

// File: logic/csi_byte_capture.sv
// per-byte read data gathering for narrow memories
`timescale 1ns/1ns
`default_nettype none
module csi_byte_capture
   import csi_pkg::*;
#(
   parameter int NBYTES = BYTES
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic capture_en_i,
   input wire logic clear_i,
   input wire logic [NBYTES-1:0] be_i,
   input wire logic [8*NBYTES-1:0] data_i,
   output logic [8*NBYTES-1:0] data_o,
   output logic [8*NBYTES-1:0] merged_o
);
   typedef struct packed {
      logic [8*NBYTES-1:0] data;
   } csi_cap_type;

   csi_cap_type st_reg;
   csi_cap_type st_next;

   // only flagged lanes replace the held byte
   for (genvar b = 0; b < NBYTES; b++) begin : g_lane
      assign merged_o[8*b +: 8] = be_i[b] ? data_i[8*b +: 8] :
         st_reg.data[8*b +: 8];
   end

   // clear wins so a new transaction never sees stale bytes
   always_comb begin
      st_next = st_reg;
      if (clear_i) begin
         st_next.data = '0;
      end else if (capture_en_i) begin
         st_next.data = merged_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign data_o = st_reg.data;

   lane_capture_a: assert property (@(posedge clk_i) disable iff (reset_i)
      capture_en_i && !clear_i && be_i[0]
      |=> data_o[7:0] == $past(data_i[7:0]))
      else $error("flagged byte lane not captured");
endmodule // csi_byte_capture
`default_nettype wire

// File: logic/csi_pkg.sv
// constants, port record and power states for the core sram interface
package csi_pkg;
   localparam int DATA_W = 32;
   localparam int BYTES = 4;
   // status and debug word bit positions mirrored to the pins
   localparam int REDUCED_POWER_POS = 27;
   localparam int EXCEPTION_LEVEL_POS = 1;
   localparam int ERROR_LEVEL_POS = 2;
   localparam int DEBUG_MODE_POS = 30;
   // least hold time of either reset pin, in core cycles
   localparam int RESET_MIN_CYC = 5;
   localparam logic [3:0] SYNC_RESET = 4'h0;
   localparam logic [31:0] WORD_ZERO = 32'h0;

   // one memory port transaction, also used for the redirect holding slot
   typedef struct packed {
      logic busy;
      logic owner_d;
      logic write;
      logic lock;
      logic sync;
      logic call;
      logic abort;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } csi_port_type;

   typedef enum logic [1:0] {
      CSI_RUN = 2'b01,
      CSI_SLEEP = 2'b10
   } csi_power_type;

   // build a fresh transaction record from a request
   function automatic csi_port_type csi_launch(input logic owner_d,
      input logic [31:0] addr, input logic [31:0] wdata, input logic write,
      input logic [3:0] be, input logic lock, input logic sync,
      input logic call);
      csi_port_type p;
      p.busy = 1'b1;
      p.owner_d = owner_d;
      p.write = write;
      p.lock = lock;
      p.sync = sync;
      p.call = call;
      p.abort = 1'b0;
      p.addr = addr;
      p.wdata = wdata;
      p.be = be;
      return p;
   endfunction
endpackage

// File: logic/csi_top.sv
// core sram-style memory interface and system sideband
`timescale 1ns/1ns
`default_nettype none
module csi_top
   import csi_pkg::*;
#(
   parameter bit UNIFIED = 1'b0,
   parameter bit DEBUG_MASK_EN = 1'b1
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic core_i_valid_i,
   input wire logic [31:0] core_i_addr_i,
   input wire logic core_i_call_i,
   output logic core_i_ready_o,
   output logic core_i_done_o,
   output logic core_i_aborted_o,
   output logic [31:0] core_i_rdata_o,
   input wire logic core_d_valid_i,
   input wire logic [31:0] core_d_addr_i,
   input wire logic [31:0] core_d_wdata_i,
   input wire logic core_d_write_i,
   input wire logic [3:0] core_d_be_i,
   input wire logic core_d_lock_i,
   input wire logic core_d_sync_i,
   output logic core_d_ready_o,
   output logic core_d_done_o,
   output logic core_d_aborted_o,
   output logic [31:0] core_d_rdata_o,
   input wire logic irq_detect_i,
   input wire logic fetch_abort_i,
   input wire logic wait_exec_i,
   input wire logic [31:0] status_word_i,
   input wire logic [31:0] debug_word_i,
   input wire logic debug_reset_mask_i,
   output logic ip_req_o,
   output logic ip_dside_o,
   output logic ip_write_o,
   output logic [31:0] ip_addr_o,
   output logic [31:0] ip_wdata_o,
   output logic [3:0] ip_be_o,
   output logic ip_lock_o,
   output logic ip_sync_o,
   output logic ip_call_o,
   output logic ip_abort_o,
   input wire logic ip_stall_i,
   input wire logic ip_abort_ack_i,
   input wire logic [31:0] ip_rdata_i,
   input wire logic [3:0] ip_rbe_i,
   output logic dp_req_o,
   output logic dp_write_o,
   output logic [31:0] dp_addr_o,
   output logic [31:0] dp_wdata_o,
   output logic [3:0] dp_be_o,
   output logic dp_lock_o,
   output logic dp_sync_o,
   output logic dp_abort_o,
   input wire logic dp_stall_i,
   input wire logic dp_abort_ack_i,
   input wire logic [31:0] dp_rdata_i,
   input wire logic [3:0] dp_rbe_i,
   input wire logic dside_redirect_i,
   input wire logic warm_reset_in_i,
   input wire logic cold_reset_in_i,
   input wire logic interrupt_pin_i,
   input wire logic nmi_pin_i,
   output logic reset_exception_o,
   output logic soft_reset_flag_o,
   output logic reduced_power_out_o,
   output logic exception_level_out_o,
   output logic error_level_out_o,
   output logic debug_mode_out_o,
   output logic sleep_o,
   output logic core_clk_en_o
);
   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic comb_prev;
      logic warm_only;
      logic rst_exc;
      logic soft_flag;
      logic [3:0] mirror;
      csi_power_type pwr;
      csi_port_type ip;
      csi_port_type dp;
      csi_port_type redir;
      logic i_done;
      logic i_aborted;
      logic [31:0] i_rdata;
      logic d_done;
      logic d_aborted;
      logic [31:0] d_rdata;
   } csi_state_type;

   localparam csi_state_type ST_RESET = '{sync1: SYNC_RESET,
      sync2: SYNC_RESET, comb_prev: 1'b0, warm_only: 1'b0, rst_exc: 1'b0,
      soft_flag: 1'b0, mirror: 4'h0, pwr: CSI_RUN, ip: '0, dp: '0,
      redir: '0, i_done: 1'b0, i_aborted: 1'b0, i_rdata: WORD_ZERO,
      d_done: 1'b0, d_aborted: 1'b0, d_rdata: WORD_ZERO};

   csi_state_type st_reg;
   csi_state_type st_next;

   logic warm_s, cold_s, int_s, nmi_s, warm_eff, comb_s, wake, awake;
   logic ip_done, dp_done, ip_acked, dp_acked, ip_free, dp_free;
   logic redir_go, ud_go, d_hold;
   logic [31:0] ip_merged, dp_merged;

   // pins are asynchronous, so only the second stage is read
   assign warm_s = st_reg.sync2[0];
   assign cold_s = st_reg.sync2[1];
   assign int_s = st_reg.sync2[2];
   assign nmi_s = st_reg.sync2[3];
   // debug may hold off warm reset only while in debug mode
   assign warm_eff = warm_s & ~(DEBUG_MASK_EN &
      debug_word_i[DEBUG_MODE_POS] & debug_reset_mask_i);
   assign comb_s = warm_eff | cold_s;
   assign wake = int_s | nmi_s | comb_s;
   assign awake = (st_reg.pwr == CSI_RUN);

   // completion: stall low ends it, or an acknowledged abort
   assign ip_acked = st_reg.ip.abort & ip_abort_ack_i;
   assign dp_acked = st_reg.dp.abort & dp_abort_ack_i;
   assign ip_done = st_reg.ip.busy & (~ip_stall_i | ip_acked);
   assign dp_done = st_reg.dp.busy & (~dp_stall_i | dp_acked);
   assign ip_free = ~st_reg.ip.busy | ip_done;
   assign dp_free = ~st_reg.dp.busy | dp_done;

   // i-port arbitration: redirected or unified data beats fetch
   assign redir_go = ~UNIFIED & st_reg.redir.busy;
   assign ud_go = UNIFIED & core_d_valid_i;
   assign d_hold = ~UNIFIED & (st_reg.redir.busy |
      (st_reg.ip.busy & st_reg.ip.owner_d));
   assign core_i_ready_o = ip_free & awake & ~redir_go & ~ud_go;
   assign core_d_ready_o = UNIFIED ? (ip_free & awake) :
      (dp_free & awake & ~d_hold);

   csi_byte_capture #(.NBYTES(BYTES)) u_ip_cap (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .capture_en_i(st_reg.ip.busy),
      .clear_i(ip_done),
      .be_i(ip_rbe_i),
      .data_i(ip_rdata_i),
      .data_o(),
      .merged_o(ip_merged)
   );

   csi_byte_capture #(.NBYTES(BYTES)) u_dp_cap (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .capture_en_i(st_reg.dp.busy),
      .clear_i(dp_done),
      .be_i(dp_rbe_i),
      .data_i(dp_rdata_i),
      .data_o(),
      .merged_o(dp_merged)
   );

   // advance one port: finish, or keep the request and latch abort
   function automatic csi_port_type csi_step(input csi_port_type p,
      input logic done, input logic cause);
      csi_port_type r;
      r = p;
      if (done) begin
         r = '0;
      end else if (p.busy && cause) begin
         r.abort = 1'b1;
      end
      return r;
   endfunction

   always_comb begin
      st_next = st_reg;
      st_next.sync1 = {nmi_pin_i, interrupt_pin_i, cold_reset_in_i,
         warm_reset_in_i};
      st_next.sync2 = st_reg.sync1;
      // status and debug levels follow the words one cycle late
      st_next.mirror = {debug_word_i[DEBUG_MODE_POS],
         status_word_i[ERROR_LEVEL_POS],
         status_word_i[EXCEPTION_LEVEL_POS],
         status_word_i[REDUCED_POWER_POS]};
      // reset exception fires on the falling edge, not during reset
      st_next.comb_prev = comb_s;
      st_next.rst_exc = st_reg.comb_prev & ~comb_s;
      if (comb_s) begin
         st_next.warm_only = warm_eff & ~cold_s;
      end
      if (st_reg.comb_prev && !comb_s) begin
         st_next.soft_flag = st_reg.warm_only;
      end
      // results: one-cycle done pulses with gathered read data
      st_next.i_done = 1'b0;
      st_next.d_done = 1'b0;
      st_next.i_aborted = 1'b0;
      st_next.d_aborted = 1'b0;
      if (ip_done && st_reg.ip.owner_d) begin
         st_next.d_done = 1'b1;
         st_next.d_aborted = ip_acked;
         st_next.d_rdata = ip_merged;
      end else if (ip_done) begin
         st_next.i_done = 1'b1;
         st_next.i_aborted = ip_acked;
         st_next.i_rdata = ip_merged;
      end
      if (dp_done) begin
         st_next.d_done = 1'b1;
         st_next.d_aborted = dp_acked;
         st_next.d_rdata = dp_merged;
      end
      st_next.ip = csi_step(st_reg.ip, ip_done, irq_detect_i |
         (fetch_abort_i & ~st_reg.ip.owner_d));
      st_next.dp = csi_step(st_reg.dp, dp_done, irq_detect_i);
      // i-port launch in priority order
      if (ip_free && awake) begin
         if (redir_go) begin
            st_next.ip = st_reg.redir;
            st_next.redir = '0;
         end else if (ud_go) begin
            st_next.ip = csi_launch(1'b1, core_d_addr_i, core_d_wdata_i,
               core_d_write_i, core_d_be_i, core_d_lock_i, core_d_sync_i,
               1'b0);
         end else if (core_i_valid_i) begin
            st_next.ip = csi_launch(1'b0, core_i_addr_i, WORD_ZERO, 1'b0,
               4'hf, 1'b0, 1'b0, core_i_call_i);
         end
      end
      // dual data side: own port, or parked until the i-port is free
      if (!UNIFIED && core_d_valid_i && core_d_ready_o) begin
         if (dside_redirect_i) begin
            st_next.redir = csi_launch(1'b1, core_d_addr_i, core_d_wdata_i,
               core_d_write_i, core_d_be_i, core_d_lock_i, core_d_sync_i,
               1'b0);
         end else begin
            st_next.dp = csi_launch(1'b1, core_d_addr_i, core_d_wdata_i,
               core_d_write_i, core_d_be_i, core_d_lock_i, core_d_sync_i,
               1'b0);
         end
      end
      // wake beats a wait in the same cycle so no interrupt is slept on
      case (st_reg.pwr)
         CSI_RUN: begin
            if (wait_exec_i && !wake) begin
               st_next.pwr = CSI_SLEEP;
            end
         end
         CSI_SLEEP: begin
            if (wake) begin
               st_next.pwr = CSI_RUN;
            end
         end
         default: begin
            st_next.pwr = CSI_RUN;
         end
      endcase
      // pin reset clears the transaction state
      if (comb_s) begin
         st_next.ip = '0;
         st_next.dp = '0;
         st_next.redir = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // memory ports straight from the transaction records
   assign ip_req_o = st_reg.ip.busy;
   assign ip_dside_o = st_reg.ip.owner_d;
   assign ip_write_o = st_reg.ip.write;
   assign ip_addr_o = st_reg.ip.addr;
   assign ip_wdata_o = st_reg.ip.wdata;
   assign ip_be_o = st_reg.ip.be;
   assign ip_lock_o = st_reg.ip.lock;
   assign ip_sync_o = st_reg.ip.sync;
   assign ip_call_o = st_reg.ip.call;
   assign ip_abort_o = st_reg.ip.abort;
   assign dp_req_o = st_reg.dp.busy;
   assign dp_write_o = st_reg.dp.write;
   assign dp_addr_o = st_reg.dp.addr;
   assign dp_wdata_o = st_reg.dp.wdata;
   assign dp_be_o = st_reg.dp.be;
   assign dp_lock_o = st_reg.dp.lock;
   assign dp_sync_o = st_reg.dp.sync;
   assign dp_abort_o = st_reg.dp.abort;
   // core side results and sideband levels
   assign core_i_done_o = st_reg.i_done;
   assign core_i_aborted_o = st_reg.i_aborted;
   assign core_i_rdata_o = st_reg.i_rdata;
   assign core_d_done_o = st_reg.d_done;
   assign core_d_aborted_o = st_reg.d_aborted;
   assign core_d_rdata_o = st_reg.d_rdata;
   assign reset_exception_o = st_reg.rst_exc;
   assign soft_reset_flag_o = st_reg.soft_flag;
   assign reduced_power_out_o = st_reg.mirror[0];
   assign exception_level_out_o = st_reg.mirror[1];
   assign error_level_out_o = st_reg.mirror[2];
   assign debug_mode_out_o = st_reg.mirror[3];
   assign sleep_o = (st_reg.pwr == CSI_SLEEP);
   assign core_clk_en_o = awake;

   request_hold_a: assert property (@(posedge clk_i)
      disable iff (reset_i || comb_s)
      ip_req_o && ip_stall_i && !(ip_abort_o && ip_abort_ack_i)
      |=> ip_req_o && $stable(ip_addr_o))
      else $error("stalled request dropped or changed");
   unified_prio_a: assert property (@(posedge clk_i) disable iff (reset_i)
      UNIFIED && core_i_valid_i && core_d_valid_i |-> !core_i_ready_o)
      else $error("fetch granted over data in unified mode");
   redirect_stall_a: assert property (@(posedge clk_i)
      disable iff (reset_i || comb_s)
      !UNIFIED && core_d_valid_i && core_d_ready_o && dside_redirect_i
      |=> !core_d_ready_o ##0 !dp_req_o || $past(dp_req_o))
      else $error("data side not stalled after redirect");
   abort_raise_a: assert property (@(posedge clk_i)
      disable iff (reset_i || comb_s)
      ip_req_o && ip_stall_i && !ip_abort_ack_i && irq_detect_i
      |=> ip_abort_o && ip_req_o)
      else $error("no abort for interrupt during transaction");
   abort_drop_a: assert property (@(posedge clk_i)
      disable iff (reset_i || comb_s)
      ip_abort_o && ip_abort_ack_i |=> !ip_abort_o ##1 !ip_abort_o
      || ip_req_o)
      else $error("abort held after acknowledge");
   level_mirror_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 reduced_power_out_o == $past(status_word_i[REDUCED_POWER_POS])
      && error_level_out_o == $past(status_word_i[ERROR_LEVEL_POS]))
      else $error("power or error level not mirrored");
   debug_mirror_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 debug_mode_out_o == $past(debug_word_i[DEBUG_MODE_POS]))
      else $error("debug mode not mirrored");
   reset_fall_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(comb_s) |=> reset_exception_o ##1 !reset_exception_o)
      else $error("reset exception not on falling edge");
   cold_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(comb_s) && $past(cold_s) |=> !soft_reset_flag_o)
      else $error("soft flag set by cold reset");
   sleep_enter_a: assert property (@(posedge clk_i) disable iff (reset_i)
      awake && wait_exec_i && !wake |=> sleep_o && !core_clk_en_o)
      else $error("wait did not enter sleep");
   sleep_exit_a: assert property (@(posedge clk_i) disable iff (reset_i)
      sleep_o && wake |=> !sleep_o && core_clk_en_o)
      else $error("sleep not left on wake event");
endmodule // csi_top
`default_nettype wire
